// >>> rtl/slb_responder.sv
`timescale 1ns/100ps
// Notes on behaviour
// - retimed loopback always; analog modes optional
// - only activate-self-test word enters loopback
// - stay looped until comreset or cominit
// - echo recovered stream, aligns inserted as needed; here passed one for one
// - descramble then rescramble with identical syndromes
// - returned dwords equal received; disparity free
// - initiator budgets two consumed aligns per window
// - initiator extra aligns in one burst
// - responder may drop zero to two aligns
// - inserted aligns keep every run two long
// - doubled input aligns give runs of two plus
// - checker ignores align positions
// - initiator sends only valid characters
// - compare decoded bytes, not raw characters
// - loop echoes all, ignoring primitive meaning
// - far analog entered by frame, left by oob
// - near analog only while far end silent
// - align pair before every 256-dword wrap
// - outside loopback aligns always in pairs
module slb_responder
    import slb_pkg::*;
#(
    parameter bit HAS_FAR_ANALOG = 1'b1, // optional far analog mode
    parameter bit HAS_NEAR_ANALOG = 1'b1 // optional near analog mode
) (
    input wire logic mclk_in, // 125 MHz link word clock
    input wire logic reset_n_in, // async reset, active low
    slb_link_if.responder link, // link to the initiator
    input wire logic [slb_pkg::DW-1:0] usr_tx_data_in, // normal-mode payload
    output logic usr_tx_ready_out, // payload taken this edge
    output logic [slb_pkg::DW-1:0] usr_rx_data_out, // received, descrambled in retimed loop
    output logic usr_rx_valid_out, // one-cycle strobe for rx data
    input wire logic near_req_in, // request near analog loop
    output logic near_loop_out, // near analog loop engaged
    output logic [1:0] mode_out // 0 normal 1 retimed 2 far analog
);
    import slb_pkg::*;

    // ==========================================================
    // mode control
    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_RETIMED = 2'h1,
        ST_FAR_ANALOG = 2'h2
    } slb_rsp_state_e;

    slb_rsp_state_e state_r;
    slb_rsp_state_e state_nxt;
    logic oob_exit;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [DW-1:0] rx_scr_r;
    logic [DW-1:0] tx_scr_r;
    logic [DW-1:0] hold_data_r;
    slb_kind_e hold_kind_r;
    logic [DW-1:0] desc_data;

    assign oob_exit = (link.i2r_oob == OOB_COMRESET) || (link.i2r_oob == OOB_COMINIT);

    // entry only by the activate word, exit only by oob reset signalling
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (link.i2r_kind == K_BIST) begin
                    if (link.i2r_data[BIST_MODE_LSB +: 2] == BIST_RETIMED) begin
                        state_nxt = ST_RETIMED;
                    end else if (HAS_FAR_ANALOG &&
                                 link.i2r_data[BIST_MODE_LSB +: 2] == BIST_FAR_ANALOG) begin
                        state_nxt = ST_FAR_ANALOG;
                    end
                end
            end
            ST_RETIMED: begin
                if (oob_exit) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_FAR_ANALOG: begin
                if (oob_exit) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_out <= 2'h0;
        end else begin
            mode_out <= state_nxt;
        end
    end

    // ==========================================================
    // normal-mode align pacing
    // the counter free-runs in every mode, in step with the initiator's window
    // from the shared reset; loop entry and exit then never cut a pair in two
    assign cnt_nxt = cnt_r + 1'b1;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ready is staged one edge ahead so the port stays a plain flop
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            usr_tx_ready_out <= 1'b0;
        end else begin
            usr_tx_ready_out <= (state_nxt == ST_NORMAL) && (cnt_nxt < ALIGN_PAIR_START);
        end
    end

    // ==========================================================
    // descramble with the same syndrome walk the transmit side will use
    assign desc_data = link.i2r_data ^ rx_scr_r;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_scr_r <= SCR_SEED;
        end else if (state_r != ST_RETIMED) begin
            rx_scr_r <= SCR_SEED;
        end else if (link.i2r_kind == K_DATA) begin
            rx_scr_r <= lfsr_next(rx_scr_r);
        end
    end

    // hold stage: every word is kept whatever it means, primitives included
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_data_r <= IDLE_FILL;
            hold_kind_r <= K_IDLE;
        end else begin
            hold_data_r <= (link.i2r_kind == K_DATA) ? desc_data : link.i2r_data;
            hold_kind_r <= link.i2r_kind;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_scr_r <= SCR_SEED;
        end else if (state_r != ST_RETIMED) begin
            tx_scr_r <= SCR_SEED;
        end else if (hold_kind_r == K_DATA) begin
            tx_scr_r <= lfsr_next(tx_scr_r);
        end
    end

    // ==========================================================
    // transmit selection
    // one clock serves both ends, so no elastic slip is ever needed: aligns
    // are passed through one for one, which removes none and inserts none
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link.r2i_data <= IDLE_FILL;
            link.r2i_kind <= K_IDLE;
        end else if (state_r == ST_RETIMED && !oob_exit) begin
            // fixed two-word latency; disparity restarts in our own encoder
            link.r2i_kind <= hold_kind_r;
            link.r2i_data <= (hold_kind_r == K_DATA) ? (hold_data_r ^ tx_scr_r)
                                                     : hold_data_r;
        end else if (state_r == ST_FAR_ANALOG && !oob_exit) begin
            // raw return with no descrambling; a quick connectivity check only
            link.r2i_kind <= link.i2r_kind;
            link.r2i_data <= link.i2r_data;
        end else if (cnt_r >= ALIGN_PAIR_START) begin
            link.r2i_kind <= K_ALIGN;
            link.r2i_data <= IDLE_FILL;
        end else begin
            link.r2i_kind <= K_DATA;
            link.r2i_data <= usr_tx_data_in;
        end
    end

    // the responder never originates oob signalling
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link.r2i_oob <= OOB_NONE;
        end else begin
            link.r2i_oob <= OOB_NONE;
        end
    end

    // ==========================================================
    // user receive view: plain data in normal mode, descrambled in retimed loop
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            usr_rx_data_out <= IDLE_FILL;
            usr_rx_valid_out <= 1'b0;
        end else begin
            usr_rx_valid_out <= (link.i2r_kind == K_DATA) && (state_r != ST_FAR_ANALOG);
            usr_rx_data_out <= (state_r == ST_RETIMED) ? desc_data : link.i2r_data;
        end
    end

    // near analog loop only while the partner sends nothing at all
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            near_loop_out <= 1'b0;
        end else begin
            near_loop_out <= HAS_NEAR_ANALOG && near_req_in && (state_nxt == ST_NORMAL) &&
                             (link.i2r_kind == K_IDLE);
        end
    end

endmodule // slb_responder

// >>> rtl/slb_pkg.sv
// ==========================================================
// shared constants for the loopback self-test link
package slb_pkg;
    localparam int DW = 32;
    // link word class; idle means the sender is silent (power managed)
    typedef enum logic [1:0] {
        K_DATA = 2'h0,
        K_ALIGN = 2'h1,
        K_BIST = 2'h2,
        K_IDLE = 2'h3
    } slb_kind_e;
    // out-of-band signalling events
    typedef enum logic [1:0] {
        OOB_NONE = 2'h0,
        OOB_COMRESET = 2'h1,
        OOB_COMINIT = 2'h2,
        OOB_COMWAKE = 2'h3
    } slb_oob_e;
    // mode codes carried in the low bits of an activate-self-test word
    localparam logic [1:0] BIST_RETIMED = 2'h1;
    localparam logic [1:0] BIST_FAR_ANALOG = 2'h2;
    localparam logic [1:0] BIST_MODE_LSB = 2'h0;
    // align pacing: a pair closes every window of 256 dwords
    localparam int ALIGN_PERIOD = 256;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] ALIGN_PAIR_START = CNT_W'(ALIGN_PERIOD - 2);
    // scrambler and test pattern seeds (arbitrary values)
    localparam logic [DW-1:0] SCR_SEED = 32'hffff_ffff;
    localparam logic [DW-1:0] PAT_SEED = 32'h1234_5678;
    localparam logic [DW-1:0] IDLE_FILL = 32'h0000_0000;
    // one step of the shared 32-bit lfsr
    function automatic logic [DW-1:0] lfsr_next(input logic [DW-1:0] v);
        lfsr_next = {v[DW-2:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
endpackage

// >>> rtl/slb_link_if.sv
`timescale 1ns/100ps
// ==========================================================
// decoded dword-level link between initiator and responder
interface slb_link_if;
    import slb_pkg::*;
    logic [DW-1:0] i2r_data;
    slb_kind_e i2r_kind;
    slb_oob_e i2r_oob;
    logic [DW-1:0] r2i_data;
    slb_kind_e r2i_kind;
    slb_oob_e r2i_oob;
    modport initiator (
        output i2r_data, i2r_kind, i2r_oob,
        input r2i_data, r2i_kind, r2i_oob
    );
    modport responder (
        input i2r_data, i2r_kind, i2r_oob,
        output r2i_data, r2i_kind, r2i_oob
    );
endinterface

// >>> rtl/slb_initiator.sv
`timescale 1ns/100ps
module slb_initiator
    import slb_pkg::*;
#(
    parameter int EXTRA_ALIGNS = 2, // extra aligns for the partner to consume
    parameter int ERR_W = 16 // error counter width
) (
    input wire logic mclk_in, // 125 MHz link word clock
    input wire logic reset_n_in, // async reset, active low
    slb_link_if.initiator link, // link to the responder
    input wire logic start_in, // pulse: begin a loopback test
    input wire logic [1:0] mode_in, // requested loop mode code
    input wire logic stop_in, // pulse: end test with comreset
    input wire logic silent_in, // hold transmitter silent while idle (power managed)
    output logic busy_out, // test in progress
    output logic synced_out, // checker found pattern start
    output logic mismatch_out, // sticky data mismatch seen
    output logic [ERR_W-1:0] err_cnt_out // mismatching dwords, saturating
);
    import slb_pkg::*;

    // ==========================================================
    // test sequencing
    typedef enum logic [1:0] {
        SI_IDLE = 2'h0,
        SI_ACTIVATE = 2'h1,
        SI_TEST = 2'h2,
        SI_RESET = 2'h3
    } slb_ini_state_e;

    localparam logic [CNT_W-1:0] TEST_BURST_START = CNT_W'(ALIGN_PERIOD - 2 - EXTRA_ALIGNS);
    localparam logic [ERR_W-1:0] ERR_MAX = '1;
    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(ALIGN_PERIOD - 1);

    slb_ini_state_e state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DW-1:0] pat_r;
    logic [DW-1:0] exp_r;
    logic in_burst;
    logic chk_data;
    logic start_pend_r;
    logic silent_r;
    logic start_ok;

    // a start waits for the window end, so the activate word opens a window
    // and no run of non-align words grows past one window
    assign start_ok = (start_pend_r || start_in) && !silent_in;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            start_pend_r <= 1'b0;
        end else begin
            start_pend_r <= start_ok && (state_r == SI_IDLE) && (cnt_r != WIN_LAST);
        end
    end

    // silence changes only at a window end, so no align burst is cut short
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            silent_r <= 1'b0;
        end else if (cnt_r == WIN_LAST) begin
            silent_r <= silent_in;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= SI_IDLE;
        end else begin
            case (state_r)
                SI_IDLE: begin
                    if (start_ok && cnt_r == WIN_LAST) begin
                        state_r <= SI_ACTIVATE;
                    end
                end
                SI_ACTIVATE: begin
                    state_r <= SI_TEST;
                end
                SI_TEST: begin
                    if (stop_in) begin
                        state_r <= SI_RESET;
                    end
                end
                SI_RESET: begin
                    state_r <= SI_IDLE;
                end
                default: begin
                    state_r <= SI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state_r == SI_IDLE) ? start_ok : (state_r != SI_RESET);
        end
    end

    // ==========================================================
    // transmit: one burst of 2 + EXTRA_ALIGNS aligns closes every window in
    // every state except silent idle, so a stop or a start can never leave a lone align behind
    assign in_burst = (cnt_r >= TEST_BURST_START);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pat_r <= PAT_SEED;
        end else if (state_r != SI_TEST) begin
            pat_r <= PAT_SEED;
        end else if (!in_burst) begin
            pat_r <= lfsr_next(pat_r);
        end
    end

    // only data and align words go out during the test
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link.i2r_kind <= K_IDLE;
            link.i2r_data <= IDLE_FILL;
            link.i2r_oob <= OOB_NONE;
        end else begin
            link.i2r_oob <= (state_r == SI_RESET) ? OOB_COMRESET : OOB_NONE;
            if (state_r == SI_ACTIVATE) begin
                link.i2r_kind <= K_BIST;
                link.i2r_data <= {{(DW-2){1'b0}}, mode_in};
            end else if (state_r == SI_IDLE && silent_r) begin
                link.i2r_kind <= K_IDLE;
                link.i2r_data <= IDLE_FILL;
            end else if (in_burst) begin
                link.i2r_kind <= K_ALIGN;
                link.i2r_data <= IDLE_FILL;
            end else begin
                link.i2r_kind <= K_DATA;
                link.i2r_data <= (state_r == SI_TEST) ? pat_r : IDLE_FILL;
            end
        end
    end

    // ==========================================================
    // checker: aligns dropped, decoded dwords compared in order
    assign chk_data = (state_r == SI_TEST) && (link.r2i_kind == K_DATA);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            synced_out <= 1'b0;
            exp_r <= PAT_SEED;
        end else if (state_r != SI_TEST) begin
            synced_out <= 1'b0;
            exp_r <= PAT_SEED;
        end else if (chk_data && (synced_out || link.r2i_data == PAT_SEED)) begin
            synced_out <= 1'b1;
            exp_r <= lfsr_next(synced_out ? exp_r : PAT_SEED);
        end
    end

    // cleared only at start, when no compare can be in flight
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mismatch_out <= 1'b0;
            err_cnt_out <= '0;
        end else if (state_r == SI_ACTIVATE) begin
            mismatch_out <= 1'b0;
            err_cnt_out <= '0;
        end else if (chk_data && synced_out && link.r2i_data != exp_r) begin
            mismatch_out <= 1'b1;
            if (err_cnt_out != ERR_MAX) begin
                err_cnt_out <= err_cnt_out + 1'b1;
            end
        end
    end

endmodule // slb_initiator

// >>> tb/slb_link_properties.sv
`timescale 1ns/100ps
// ==========================================================
// link properties, watched beside the shared interface
module slb_link_properties
    import slb_pkg::*;
#(
    parameter int EXTRA_ALIGNS = 2 // same as the initiator
) (
    input wire logic mclk_in, // link word clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic [slb_pkg::DW-1:0] i2r_data, // initiator word
    input slb_pkg::slb_kind_e i2r_kind, // initiator word class
    input slb_pkg::slb_oob_e i2r_oob, // initiator oob event
    input wire logic [slb_pkg::DW-1:0] r2i_data, // responder word
    input slb_pkg::slb_kind_e r2i_kind, // responder word class
    input slb_pkg::slb_oob_e r2i_oob // responder oob event
);
    logic retimed_r;
    logic analog_r;
    logic [8:0] run_r;
    logic [3:0] burst_r;
    logic exit_req;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    // ==========================================================
    // helper state
    // loop state mirrored from the initiator; comwake must not end it
    assign exit_req = (i2r_oob == OOB_COMRESET) || (i2r_oob == OOB_COMINIT);
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            retimed_r <= 1'b0;
            analog_r <= 1'b0;
        end else if (exit_req) begin
            retimed_r <= 1'b0;
            analog_r <= 1'b0;
        end else if (!retimed_r && !analog_r && i2r_kind == K_BIST) begin
            retimed_r <= (i2r_data[1:0] == BIST_RETIMED);
            analog_r <= (i2r_data[1:0] == BIST_FAR_ANALOG);
        end
    end

    // run lengths of non-align words and of align bursts, saturating
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_r <= 9'h000;
            burst_r <= 4'h0;
        end else begin
            if (i2r_kind == K_ALIGN || i2r_kind == K_IDLE) begin
                run_r <= 9'h000;
            end else if (run_r != 9'h1ff) begin
                run_r <= run_r + 9'h001;
            end
            if (i2r_kind != K_ALIGN) begin
                burst_r <= 4'h0;
            end else if (burst_r != 4'hf) begin
                burst_r <= burst_r + 4'h1;
            end
        end
    end

    // ==========================================================
    // assertions
    i2r_pace_a: assert property (run_r <= 9'h0fe)
        else $error("initiator sent too many words between aligns");
    i2r_pairs_a: assert property ($rose(i2r_kind == K_ALIGN) |=> i2r_kind == K_ALIGN)
        else $error("initiator sent a lone align");
    r2i_bursts_a: assert property ($rose(r2i_kind == K_ALIGN) |=> r2i_kind == K_ALIGN)
        else $error("responder returned an align burst shorter than two");
    extra_burst_a: assert property ((retimed_r || analog_r) &&
        $past(i2r_kind) == K_ALIGN && i2r_kind != K_ALIGN |-> burst_r >= 4'(2 + EXTRA_ALIGNS))
        else $error("initiator align burst too short in loop");
    retimed_echo_a: assert property ((retimed_r && i2r_oob == OOB_NONE ##1
        i2r_oob == OOB_NONE) |=> r2i_kind == $past(i2r_kind, 2) && r2i_data == $past(i2r_data, 2))
        else $error("retimed echo differs from received word");
    analog_echo_a: assert property (analog_r && i2r_oob == OOB_NONE |=>
        r2i_kind == $past(i2r_kind) && r2i_data == $past(i2r_data))
        else $error("far analog echo differs from received word");
    resp_no_oob_a: assert property (r2i_oob == OOB_NONE)
        else $error("responder sent an oob event");
    loop_valid_a: assert property ((retimed_r || analog_r) && i2r_oob == OOB_NONE |->
        i2r_kind != K_IDLE)
        else $error("initiator went silent in loop");
endmodule // slb_link_properties

// >>> tb/serial_link_loopback_test_tb.sv
`timescale 1ns/100ps
// ==========================================================
// both ends joined back to back; bench drives the user sides
module serial_link_loopback_test_tb;
    import slb_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [DW-1:0] tx_word = 32'h0000_0000;
    logic near_req = 1'b0;
    logic start = 1'b0;
    logic [1:0] mode_req = 2'h0;
    logic stop = 1'b0;
    logic silent = 1'b0;
    logic tx_ready;
    logic near_loop;
    logic [1:0] loop_mode;
    logic busy;
    logic synced;
    logic mismatch;
    logic [15:0] err_cnt;
    logic rx_valid;
    logic [DW-1:0] rx_data;
    int err_count = 0;
    int n_compared = 0;

    slb_link_if link_if ();
    slb_responder i_slb_responder (.mclk_in(mclk), .reset_n_in(reset_n), .link(link_if),
        .usr_tx_data_in(tx_word), .usr_tx_ready_out(tx_ready), .usr_rx_data_out(rx_data),
        .usr_rx_valid_out(rx_valid), .near_req_in(near_req), .near_loop_out(near_loop),
        .mode_out(loop_mode));
    slb_initiator i_slb_initiator (.mclk_in(mclk), .reset_n_in(reset_n), .link(link_if),
        .start_in(start), .mode_in(mode_req), .stop_in(stop), .silent_in(silent),
        .busy_out(busy), .synced_out(synced), .mismatch_out(mismatch), .err_cnt_out(err_cnt));
    slb_link_properties i_props (.mclk_in(mclk), .reset_n_in(reset_n),
        .i2r_data(link_if.i2r_data), .i2r_kind(link_if.i2r_kind), .i2r_oob(link_if.i2r_oob),
        .r2i_data(link_if.r2i_data), .r2i_kind(link_if.r2i_kind), .r2i_oob(link_if.r2i_oob));

    // ==========================================================
    // clock and shared helpers
    initial begin
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a wait that used up its bound ends the run at once
    task automatic guard(input int i, input int lim);
        if (i >= lim) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, i, lim - 1);
            test_done();
        end
    endtask

    task automatic pulse(input logic is_stop, input logic [1:0] code);
        mode_req = code;
        start = !is_stop;
        stop = is_stop;
        @(negedge mclk);
        start = 1'b0;
        stop = 1'b0;
    endtask

    // ==========================================================
    // scenarios
    // reset is also used in mid-test, so mode, ready, busy and returned word class are rechecked here
    task automatic t_reset();
        reset_n = 1'b0;
        repeat (5) @(negedge mclk);
        chk(32'(loop_mode), 32'h0);
        chk(32'(tx_ready), 32'h0);
        chk(32'(busy), 32'h0);
        chk(32'(link_if.r2i_kind), 32'(K_IDLE));
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        $display("test reset done");
    endtask

    // normal traffic: 254 words, then one align pair, every window
    task automatic t_pacing();
        logic took;
        logic [DW-1:0] sent;
        int run;
        int al;
        slb_kind_e prev;
        run = -1;
        al = 0;
        for (int c = 0; c < 600; c++) begin
            tx_word = 32'h00a5_0000 + 32'(c);
            took = tx_ready;
            sent = tx_word;
            prev = link_if.i2r_kind;
            @(negedge mclk);
            chk(32'(rx_valid), 32'(prev == K_DATA));
            chk(rx_data, IDLE_FILL);
            chk(32'(link_if.r2i_kind), took ? 32'(K_DATA) : 32'(K_ALIGN));
            if (took) chk(link_if.r2i_data, sent);
            if (link_if.r2i_kind == K_ALIGN) begin
                if (run > 0) chk(32'(run), 32'h0000_00fe);
                run = 0;
                al++;
            end else begin
                if (al > 0) chk(32'(al), 32'h2);
                al = 0;
                if (run >= 0) run++;
            end
        end
        $display("test pacing done");
    endtask

    // enter a loop mode, run the pattern, leave with comreset; starts and
    // silence wait for a window end, so those waits cover a whole window
    task automatic t_loop(input logic [1:0] code, input int cycles);
        int i;
        pulse(1'b0, code);
        for (i = 0; i < 300 && loop_mode !== code; i++) @(negedge mclk);
        guard(i, 300);
        for (i = 0; i < 40 && synced !== 1'b1; i++) @(negedge mclk);
        guard(i, 40);
        repeat (cycles) @(negedge mclk);
        chk(32'(mismatch), 32'h0);
        chk(32'(err_cnt), 32'h0);
        chk(32'(tx_ready), 32'h0);
        chk(32'(loop_mode), 32'(code));
        pulse(1'b1, code);
        for (i = 0; i < 4 && link_if.i2r_oob !== OOB_COMRESET; i++) @(negedge mclk);
        guard(i, 4);
        @(negedge mclk);
        chk(32'(loop_mode), 32'h0);
        chk(32'(busy), 32'h0);
        $display("test loop %0d done", code);
    endtask

    // mode codes other than the two loops must leave the far end alone
    task automatic t_bad_code();
        logic [1:0] codes [2] = '{2'h0, 2'h3};
        int i;
        foreach (codes[k]) begin
            pulse(1'b0, codes[k]);
            for (i = 0; i < 300 && link_if.i2r_kind !== K_BIST; i++) @(negedge mclk);
            guard(i, 300);
            repeat (30) @(negedge mclk);
            chk(32'(loop_mode), 32'h0);
            pulse(1'b1, codes[k]);
            repeat (4) @(negedge mclk);
        end
        $display("test bad code done");
    endtask

    // near loop only while the initiator is silent; start refused then
    task automatic t_near();
        int i;
        silent = 1'b1;
        near_req = 1'b1;
        for (i = 0; i < 300 && near_loop !== 1'b1; i++) @(negedge mclk);
        guard(i, 300);
        pulse(1'b0, BIST_RETIMED);
        repeat (3) @(negedge mclk);
        chk(32'(busy), 32'h0);
        chk(32'(loop_mode), 32'h0);
        silent = 1'b0;
        for (i = 0; i < 300 && near_loop !== 1'b0; i++) @(negedge mclk);
        guard(i, 300);
        near_req = 1'b0;
        repeat (4) @(negedge mclk);
        $display("test near done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        t_reset();
        t_pacing();
        t_loop(BIST_RETIMED, 600);
        t_loop(BIST_FAR_ANALOG, 300);
        t_bad_code();
        t_near();
        pulse(1'b0, BIST_RETIMED);
        repeat (20) @(negedge mclk);
        t_reset();
        t_loop(BIST_RETIMED, 40);
        test_done();
    end
endmodule // serial_link_loopback_test_tb
